// >>> pkg/ncpd_pkg.sv
// Shared constants, types and opcode decode for the nibble core peripheral decoder
package ncpd_pkg;

	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_ENABLES = 12'h008;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam int ST_ACC_LSB = 0;
	localparam int ST_CF_BIT = 4;
	localparam int ST_ZF_BIT = 5;
	localparam int ST_HOLD_BIT = 6;
	localparam int ST_STOP_BIT = 7;
	localparam int ST_INTEN_BIT = 8;
	localparam int ST_SERBUSY_BIT = 9;
	localparam int EN_HOLD_LSB = 0;
	localparam int EN_INT_LSB = 8;
	localparam int EN_STOP_LSB = 16;
	localparam int EN_PORTD_BIT = 24;
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SER_BIT_NS = 80;
	localparam int SER_BASE_CYCLES = (SER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SER_BITS = 4'h8;
	localparam int DRAM_AW = 7;
	localparam int DMEM_AW = 8;

	typedef enum logic [5:0] {
		OP_NONE, OP_EV_LO, OP_EV_HI, OP_HOLD_EN, OP_PORTD_EN, OP_INT_EN, OP_PORT_EN,
		OP_PORT1_EN, OP_STOP_EN, OP_SYSCLK, OP_PS0_RD, OP_PS1_RD, OP_PS2_RD, OP_PS0_CLR,
		OP_PS1_CLR, OP_PS2_CLR, OP_CARRY_SET, OP_CARRY_CLR, OP_DIV0_CLR, OP_DIV1_CLR,
		OP_WDOG_CLR, OP_SH_RIGHT, OP_ROT_RIGHT, OP_SH_LEFT, OP_ROT_LEFT, OP_PTR_LO,
		OP_PTR_HI, OP_DM_WR, OP_DM_RD, OP_DISP_ON, OP_DISP_OFF, OP_CONTRAST, OP_SER_CTL,
		OP_SER_OUT, OP_SER_IN, OP_TONE_EN, OP_TONE_SEL, OP_T0_WLO, OP_T0_WHI, OP_T1_WLO,
		OP_T1_WHI, OP_T0_RLO, OP_T0_RHI, OP_T1_RLO, OP_T1_RHI, OP_HOLD, OP_STOP,
		OP_INT_ON, OP_INT_OFF
	} ncpd_op_t;

	typedef enum logic [2:0] {ST_FETCH, ST_READ, ST_EXEC, ST_SERIAL, ST_HOLD, ST_STOP}
		ncpd_state_t;

	function automatic ncpd_op_t ncpd_decode(input logic [15:0] w);
		ncpd_op_t op;
		op = OP_NONE;
		casez (w)
			16'b0101_1101_0???_????: op = OP_EV_LO;
			16'b0101_1101_1???_????: op = OP_EV_HI;
			16'b0100_0001_????_????: op = OP_HOLD_EN;
			16'b0011_0001_0000_000?: op = OP_PORTD_EN;
			16'b0101_0001_????_????: op = OP_INT_EN;
			16'b0100_0011_0000_????: op = OP_PORT_EN;
			16'b0011_0011_0000_??00: op = OP_PORT1_EN;
			16'b0101_0010_????_????: op = OP_STOP_EN;
			16'b0101_0100_0000_????: op = OP_SYSCLK;
			16'b0100_1111_0???_????: op = OP_PS0_RD;
			16'b0100_1111_1???_????: op = OP_PS1_RD;
			16'b0101_1111_0???_????: op = OP_PS2_RD;
			16'b0100_0010_0000_0000: op = OP_PS0_CLR;
			16'b0100_0010_1000_0000: op = OP_PS1_CLR;
			16'b0100_0010_1100_0000: op = OP_PS2_CLR;
			16'b0101_0000_0100_0000: op = OP_CARRY_SET;
			16'b0101_0000_0000_0000: op = OP_CARRY_CLR;
			16'b0001_0111_0000_0000: op = OP_DIV0_CLR;
			16'b0101_0101_1000_0000: op = OP_DIV1_CLR;
			16'b0001_0111_1000_0000: op = OP_WDOG_CLR;
			16'b0100_1101_0???_????: op = OP_SH_RIGHT;
			16'b0100_1101_1???_????: op = OP_ROT_RIGHT;
			16'b0100_1100_0???_????: op = OP_SH_LEFT;
			16'b0100_1100_1???_????: op = OP_ROT_LEFT;
			16'b1001_1000_0???_????: op = OP_PTR_LO;
			16'b1001_1000_1???_????: op = OP_PTR_HI;
			16'b1001_1010_0???_????: op = OP_DM_WR;
			16'b1001_1011_0???_????: op = OP_DM_RD;
			16'b0000_0010_0000_0000: op = OP_DISP_ON;
			16'b0000_0010_1000_0000: op = OP_DISP_OFF;
			16'b0000_0011_0000_0???: op = OP_CONTRAST;
			16'b0011_0010_0000_????: op = OP_SER_CTL;
			16'b1010_1111_0???_????: op = OP_SER_OUT;
			16'b1001_1111_0???_????: op = OP_SER_IN;
			16'b0011_0100_1000_????: op = OP_TONE_EN;
			16'b1001_1110_1???_????: op = OP_TONE_SEL;
			16'b1010_1010_0???_????: op = OP_T0_WLO;
			16'b1010_1010_1???_????: op = OP_T0_WHI;
			16'b1010_1011_0???_????: op = OP_T1_WLO;
			16'b1010_1011_1???_????: op = OP_T1_WHI;
			16'b1000_1111_0???_????: op = OP_T0_RLO;
			16'b1000_1111_1???_????: op = OP_T0_RHI;
			16'b1001_1001_0???_????: op = OP_T1_RLO;
			16'b1001_1001_1???_????: op = OP_T1_RHI;
			16'b0000_0000_1000_0000: op = OP_HOLD;
			16'b0000_0000_1100_0000: op = OP_STOP;
			16'b0101_0000_1100_0000: op = OP_INT_ON;
			16'b0101_0000_1000_0000: op = OP_INT_OFF;
			default: op = OP_NONE;
		endcase
		return op;
	endfunction : ncpd_decode

	function automatic logic ncpd_is_zero(input logic [3:0] v);
		return v == NIB_RST;
	endfunction : ncpd_is_zero

endpackage : ncpd_pkg

// >>> pkg/ncpd_ifs.sv
// Carriers between the decoder core and its memories and serial shifter
`timescale 1ns/1ns
`default_nettype none
interface ncpd_mem_if #(parameter int AW = 7);
	logic [AW-1:0] addr;
	logic [3:0] wdata;
	logic [3:0] rdata;
	logic we;
	modport host(output addr, output wdata, output we, input rdata);
	modport mem(input addr, input wdata, input we, output rdata);
endinterface : ncpd_mem_if

interface ncpd_ser_if;
	logic start;
	logic dirOut;
	logic [1:0] rate;
	logic [7:0] txByte;
	logic [7:0] rxByte;
	logic busy;
	logic done;
	modport ctrl(output start, output dirOut, output rate, output txByte,
		input rxByte, input busy, input done);
	modport shifter(input start, input dirOut, input rate, input txByte,
		output rxByte, output busy, output done);
endinterface : ncpd_ser_if
`default_nettype wire

// >>> src/ncpd_nib_mem.sv
// Nibble-wide memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module ncpd_nib_mem #(parameter int AW = 7) (
	input wire logic clk,
	input wire logic ce,
	ncpd_mem_if.mem port
);
	logic [3:0] cells [2**AW];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (port.we) begin
				cells[port.addr] <= port.wdata;
			end
			port.rdata <= cells[port.addr];
		end
	end
endmodule : ncpd_nib_mem
`default_nettype wire

// >>> src/ncpd_serial_shift.sv
// Eight-bit serial shifter on one two-way pin, MSB first
`timescale 1ns/1ns
`default_nettype none
module ncpd_serial_shift import ncpd_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	ncpd_ser_if.shifter sp,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe
);
	logic [7:0] shR;
	logic [3:0] bitCntR;
	logic [7:0] tickR;
	logic dirR;
	logic [7:0] period;

	// Slower rates double the bit time per step
	assign period = 8'(SER_BASE_CYCLES << sp.rate);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shR <= BYTE_RST;
			bitCntR <= NIB_RST;
			tickR <= BYTE_RST;
			dirR <= 1'b0;
			sp.busy <= 1'b0;
			sp.done <= 1'b0;
			sp.rxByte <= BYTE_RST;
			pinOut <= 1'b0;
			pinOe <= 1'b0;
		end else if (ce) begin
			sp.done <= 1'b0;
			if (sp.start && !sp.busy) begin
				shR <= sp.txByte;
				bitCntR <= SER_BITS;
				tickR <= period - 8'h01;
				dirR <= sp.dirOut;
				sp.busy <= 1'b1;
				pinOut <= sp.txByte[7];
				pinOe <= sp.dirOut;
			end else if (sp.busy) begin
				if (tickR == BYTE_RST) begin
					tickR <= period - 8'h01;
					shR <= {shR[6:0], dirR ? 1'b0 : pinIn};
					pinOut <= shR[6];
					bitCntR <= bitCntR - 4'h1;
					if (bitCntR == 4'h1) begin
						sp.busy <= 1'b0;
						sp.done <= 1'b1;
						pinOe <= 1'b0;
						sp.rxByte <= {shR[6:0], pinIn};
					end
				end else begin
					tickR <= tickR - 8'h01;
				end
			end
		end
	end
endmodule : ncpd_serial_shift
`default_nettype wire

// >>> src/ncpd_decoder.sv
// Peripheral opcode decoder and execution control for the nibble core
// Notes on behaviour
// - Event flag nibbles into accumulator and register
// - Immediate byte loads hold-release enables
// - Immediate bit sets port D hold-release enable
// - Immediate byte loads interrupt enable flags
// - Load port enables; port 1 bits 3,2
// - Immediate byte loads stop wake-up enables
// - Port status reads set accumulator, register, zero
// - Fixed opcodes clear one port status register
// - Clear only low four divider bits
// - Register written to display memory at pointer
// - Display memory at pointer read into register
// - Three-bit immediate sets display contrast
// - Shift register and accumulator out serially
// - Shift in byte to register, accumulator, zero
// - Four-bit immediate sets serial control
// - Register value selects tone frequency pair
// - Register writes timer preset nibbles
// - Timer nibbles read into register
// - Hold mode stops until enabled release event
// - Stop mode ends until enabled wake input
// - Fixed opcodes enable or disable interrupts
`timescale 1ns/1ns
`default_nettype none
module ncpd_decoder import ncpd_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] instr,
	input wire logic instrValid,
	output logic instrReady,
	input wire logic [7:0] eventFlags,
	input wire logic portdEvent,
	input wire logic [7:0] wakePins,
	input wire logic [11:0] portStatusSet,
	input wire logic [7:0] timer0Count,
	input wire logic [7:0] timer1Count,
	input wire logic serialPinIn,
	output logic serialPinOut,
	output logic serialPinOe,
	output logic [7:0] holdReleaseEnables,
	output logic portdHoldReleaseEnable,
	output logic [7:0] interruptEnableFlags,
	output logic interruptGlobalEnable,
	output logic [3:0] portEnableFlags,
	output logic [3:0] port1EnableFlags,
	output logic [7:0] stopWakeupEnables,
	output logic [3:0] systemClockSetting,
	output logic [11:0] portStatus,
	output logic divider0LowClear,
	output logic divider1LowClear,
	output logic watchdogRestart,
	output logic displayOn,
	output logic [2:0] displayContrastSetting,
	output logic [3:0] serialControlSetting,
	output logic [3:0] toneEnableControl,
	output logic [3:0] toneSelect,
	output logic [7:0] timer0Preset,
	output logic [7:0] timer1Preset,
	output logic holdMode,
	output logic stopMode
);
	ncpd_state_t stateR;
	ncpd_state_t stateNxt;
	logic [15:0] irR;
	ncpd_op_t op;
	logic runEnR;
	logic [3:0] accR;
	logic carryR;
	logic zeroR;
	logic [3:0] ptrLoR;
	logic [3:0] ptrHiR;
	logic exec;
	logic take;
	logic [3:0] rVal;
	logic [3:0] res;
	logic rWe;
	logic accWe;
	logic zfWe;
	logic cfWe;
	logic cfNxt;
	logic serInDone;
	logic holdWake;
	logic stopWake;
	logic apbSetup;
	logic apbWrite;
	logic addrMapped;
	logic [31:0] readMux;

	ncpd_mem_if #(.AW(DRAM_AW)) dram();
	ncpd_mem_if #(.AW(DMEM_AW)) dmem();
	ncpd_ser_if ser();

	ncpd_nib_mem #(.AW(DRAM_AW)) u_dram (
		.clk(clk),
		.ce(ce),
		.port(dram.mem)
	);

	ncpd_nib_mem #(.AW(DMEM_AW)) u_dmem (
		.clk(clk),
		.ce(ce),
		.port(dmem.mem)
	);

	ncpd_serial_shift u_ser (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.sp(ser.shifter),
		.pinIn(serialPinIn),
		.pinOut(serialPinOut),
		.pinOe(serialPinOe)
	);

	assign op = ncpd_decode(irR);
	assign exec = stateR == ST_EXEC;
	assign take = (stateR == ST_FETCH) && instrValid && instrReady;
	assign rVal = dram.rdata;
	assign serInDone = (stateR == ST_SERIAL) && ser.done && !ser.dirOut;
	assign holdWake = |(eventFlags & holdReleaseEnables) || (portdEvent && portdHoldReleaseEnable);
	assign stopWake = |(wakePins & stopWakeupEnables);

	// Data register and display memory addressing
	assign dram.addr = irR[6:0];
	assign dram.we = (exec && rWe) || serInDone;
	assign dram.wdata = serInDone ? ser.rxByte[7:4] : res;
	assign dmem.addr = {ptrHiR, ptrLoR};
	assign dmem.we = exec && (op == OP_DM_WR);
	assign dmem.wdata = rVal;

	// Sequencer: fetch, operand read, execute; wait states only for serial transfers and sleep
	always_comb begin
		stateNxt = stateR;
		unique case (stateR)
			ST_FETCH: begin
				if (take) begin
					stateNxt = ST_READ;
				end
			end
			ST_READ: stateNxt = ST_EXEC;
			ST_EXEC: begin
				if (op == OP_SER_OUT || op == OP_SER_IN) begin
					stateNxt = ST_SERIAL;
				end else if (op == OP_HOLD) begin
					stateNxt = ST_HOLD;
				end else if (op == OP_STOP) begin
					stateNxt = ST_STOP;
				end else begin
					stateNxt = ST_FETCH;
				end
			end
			ST_SERIAL: begin
				if (ser.done) begin
					stateNxt = ST_FETCH;
				end
			end
			ST_HOLD: begin
				if (holdWake) begin
					stateNxt = ST_FETCH;
				end
			end
			ST_STOP: begin
				if (stopWake) begin
					stateNxt = ST_FETCH;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateR <= ST_FETCH;
			instrReady <= 1'b0;
			irR <= 16'h0000;
			holdMode <= 1'b0;
			stopMode <= 1'b0;
		end else if (ce) begin
			stateR <= stateNxt;
			instrReady <= (stateNxt == ST_FETCH) && runEnR;
			holdMode <= stateNxt == ST_HOLD;
			stopMode <= stateNxt == ST_STOP;
			if (take) begin
				irR <= instr;
			end
		end
	end

	// Operand result and flag effects of the executing opcode
	always_comb begin
		res = NIB_RST;
		rWe = 1'b0;
		accWe = 1'b0;
		zfWe = 1'b0;
		cfWe = 1'b0;
		cfNxt = carryR;
		case (op)
			OP_EV_LO: {res, rWe, accWe, zfWe} = {eventFlags[3:0], 3'b111};
			OP_EV_HI: {res, rWe, accWe, zfWe} = {eventFlags[7:4], 3'b111};
			OP_PS0_RD: {res, rWe, accWe, zfWe} = {portStatus[3:0], 3'b111};
			OP_PS1_RD: {res, rWe, accWe, zfWe} = {portStatus[7:4], 3'b111};
			OP_PS2_RD: {res, rWe, accWe, zfWe} = {portStatus[11:8], 3'b111};
			OP_SH_RIGHT: {res, rWe, accWe, zfWe, cfWe, cfNxt} =
				{1'b0, rVal[3:1], 4'b1111, rVal[0]};
			OP_ROT_RIGHT: {res, rWe, accWe, zfWe, cfWe, cfNxt} =
				{carryR, rVal[3:1], 4'b1111, rVal[0]};
			OP_SH_LEFT: {res, rWe, accWe, zfWe, cfWe, cfNxt} =
				{rVal[2:0], 1'b0, 4'b1111, rVal[3]};
			OP_ROT_LEFT: {res, rWe, accWe, zfWe, cfWe, cfNxt} =
				{rVal[2:0], carryR, 4'b1111, rVal[3]};
			OP_CARRY_SET: {cfWe, cfNxt} = 2'b11;
			OP_CARRY_CLR: {cfWe, cfNxt} = 2'b10;
			OP_DM_RD: {res, rWe} = {dmem.rdata, 1'b1};
			OP_T0_RLO: {res, rWe} = {timer0Count[3:0], 1'b1};
			OP_T0_RHI: {res, rWe} = {timer0Count[7:4], 1'b1};
			OP_T1_RLO: {res, rWe} = {timer1Count[3:0], 1'b1};
			OP_T1_RHI: {res, rWe} = {timer1Count[7:4], 1'b1};
			default: res = NIB_RST;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			accR <= NIB_RST;
			carryR <= 1'b0;
			zeroR <= 1'b0;
		end else if (ce) begin
			if (exec && accWe) begin
				accR <= res;
			end
			if (exec && zfWe) begin
				zeroR <= ncpd_is_zero(res);
			end
			if (exec && cfWe) begin
				carryR <= cfNxt;
			end
			// Zero follows the accumulator nibble, as for the other loads
			if (serInDone) begin
				accR <= ser.rxByte[3:0];
				zeroR <= ncpd_is_zero(ser.rxByte[3:0]);
			end
		end
	end

	// Enable flag immediates
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			holdReleaseEnables <= BYTE_RST;
			portdHoldReleaseEnable <= 1'b0;
			interruptEnableFlags <= BYTE_RST;
			interruptGlobalEnable <= 1'b0;
			portEnableFlags <= NIB_RST;
			port1EnableFlags <= NIB_RST;
			stopWakeupEnables <= BYTE_RST;
			systemClockSetting <= NIB_RST;
		end else if (ce && exec) begin
			case (op)
				OP_HOLD_EN: holdReleaseEnables <= irR[7:0];
				OP_PORTD_EN: portdHoldReleaseEnable <= irR[0];
				OP_INT_EN: interruptEnableFlags <= irR[7:0];
				OP_PORT_EN: portEnableFlags <= irR[3:0];
				OP_PORT1_EN: port1EnableFlags <= {irR[3:2], 2'b00};
				OP_STOP_EN: stopWakeupEnables <= irR[7:0];
				OP_SYSCLK: systemClockSetting <= irR[3:0];
				OP_INT_ON: interruptGlobalEnable <= 1'b1;
				OP_INT_OFF: interruptGlobalEnable <= 1'b0;
				default: systemClockSetting <= systemClockSetting;
			endcase
		end
	end

	// Port status: a new event in the clearing cycle survives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portStatus <= 12'h000;
		end else if (ce) begin
			for (int i = 0; i < 3; i++) begin
				if (exec && op == ncpd_op_t'(OP_PS0_CLR + i)) begin
					portStatus[i*4 +: 4] <= portStatusSet[i*4 +: 4];
				end else begin
					portStatus[i*4 +: 4] <= portStatus[i*4 +: 4] | portStatusSet[i*4 +: 4];
				end
			end
		end
	end

	// One-cycle strobes; the dividers themselves keep their upper stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divider0LowClear <= 1'b0;
			divider1LowClear <= 1'b0;
			watchdogRestart <= 1'b0;
		end else if (ce) begin
			divider0LowClear <= exec && (op == OP_DIV0_CLR);
			divider1LowClear <= exec && (op == OP_DIV1_CLR);
			watchdogRestart <= exec && (op == OP_WDOG_CLR);
		end
	end

	// Display pointer, display state and tone settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptrLoR <= NIB_RST;
			ptrHiR <= NIB_RST;
			displayOn <= 1'b0;
			displayContrastSetting <= 3'h0;
			toneEnableControl <= NIB_RST;
			toneSelect <= NIB_RST;
			serialControlSetting <= NIB_RST;
		end else if (ce && exec) begin
			case (op)
				OP_PTR_LO: ptrLoR <= rVal;
				OP_PTR_HI: ptrHiR <= rVal;
				OP_DISP_ON: displayOn <= 1'b1;
				OP_DISP_OFF: displayOn <= 1'b0;
				OP_CONTRAST: displayContrastSetting <= irR[2:0];
				OP_SER_CTL: serialControlSetting <= irR[3:0];
				OP_TONE_EN: toneEnableControl <= irR[3:0];
				OP_TONE_SEL: toneSelect <= rVal;
				default: ptrLoR <= ptrLoR;
			endcase
		end
	end

	// Timer presets by nibble
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer0Preset <= BYTE_RST;
			timer1Preset <= BYTE_RST;
		end else if (ce && exec) begin
			case (op)
				OP_T0_WLO: timer0Preset[3:0] <= rVal;
				OP_T0_WHI: timer0Preset[7:4] <= rVal;
				OP_T1_WLO: timer1Preset[3:0] <= rVal;
				OP_T1_WHI: timer1Preset[7:4] <= rVal;
				default: timer0Preset <= timer0Preset;
			endcase
		end
	end

	// Serial launch; the core waits in its serial state until the byte is done
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser.start <= 1'b0;
			ser.dirOut <= 1'b0;
			ser.txByte <= BYTE_RST;
		end else if (ce) begin
			ser.start <= exec && (op == OP_SER_OUT || op == OP_SER_IN);
			if (exec && op == OP_SER_OUT) begin
				ser.dirOut <= 1'b1;
				ser.txByte <= {rVal, accR};
			end else if (exec && op == OP_SER_IN) begin
				ser.dirOut <= 1'b0;
			end
		end
	end

	assign ser.rate = serialControlSetting[1:0];

	// APB slave: zero wait states, error on unmapped addresses
	assign apbSetup = psel && !penable && !pready;
	assign apbWrite = psel && penable && pready && pwrite && !pslverr;
	assign addrMapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_ENABLES;

	always_comb begin
		readMux = 32'h0000_0000;
		if (paddr == ADDR_CTRL) begin
			readMux[CTRL_RUN_BIT] = runEnR;
		end else if (paddr == ADDR_STATUS) begin
			readMux[ST_ACC_LSB +: 4] = accR;
			readMux[ST_CF_BIT] = carryR;
			readMux[ST_ZF_BIT] = zeroR;
			readMux[ST_HOLD_BIT] = holdMode;
			readMux[ST_STOP_BIT] = stopMode;
			readMux[ST_INTEN_BIT] = interruptGlobalEnable;
			readMux[ST_SERBUSY_BIT] = ser.busy;
		end else if (paddr == ADDR_ENABLES) begin
			readMux[EN_HOLD_LSB +: 8] = holdReleaseEnables;
			readMux[EN_INT_LSB +: 8] = interruptEnableFlags;
			readMux[EN_STOP_LSB +: 8] = stopWakeupEnables;
			readMux[EN_PORTD_BIT] = portdHoldReleaseEnable;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			runEnR <= CTRL_RUN_RST;
		end else if (ce) begin
			pready <= apbSetup;
			pslverr <= apbSetup && !addrMapped;
			if (apbSetup) begin
				prdata <= pwrite ? 32'h0000_0000 : readMux;
			end
			if (apbWrite && paddr == ADDR_CTRL) begin
				runEnR <= pwdata[CTRL_RUN_BIT];
			end
		end
	end

endmodule : ncpd_decoder
`default_nettype wire

// >>> verif/ncpd_checker.sv
// Concurrent checks on the decoder's instruction-side outputs
`timescale 1ns/1ns
`default_nettype none
module ncpd_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] instr,
	input wire logic instrValid,
	input wire logic instrReady,
	input wire logic [7:0] holdReleaseEnables,
	input wire logic interruptGlobalEnable,
	input wire logic [3:0] port1EnableFlags,
	input wire logic divider1LowClear,
	input wire logic watchdogRestart,
	input wire logic holdMode,
	input wire logic stopMode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic tk;
	assign tk = instrValid && instrReady;
	chk_take_drop: assert property (tk |=> !instrReady)
		else $error("ready high after take");
	chk_one_cycle: assert property (tk && instr[15:12] == 4'h5 |=>
		!instrReady [*2] ##1 instrReady) else $error("cycle length wrong");
	chk_hold_load: assert property (tk && instr[15:8] == 8'h41 |->
		##3 {8'h41, holdReleaseEnables} == $past(instr, 3)) else $error("hold enables");
	chk_int_on: assert property (tk && instr == 16'h50c0 |-> ##3 interruptGlobalEnable)
		else $error("interrupt enable");
	chk_div1_cause: assert property (divider1LowClear |->
		$past(tk, 3) && $past(instr, 3) == 16'h5580) else $error("stray divider clear");
	chk_wdog_pulse: assert property (tk && instr == 16'h1780 |->
		##3 watchdogRestart ##1 !watchdogRestart) else $error("watchdog strobe");
	chk_p1_low: assert property (port1EnableFlags[1:0] == 2'h0)
		else $error("port 1 low bits set");
	chk_sleep_stall: assert property (holdMode || stopMode |-> !instrReady)
		else $error("fetch while asleep");
	cover property (tk && instr == 16'h0080);
	cover property (tk && instr == 16'haf05);
	cover property ($fell(stopMode));
endmodule : ncpd_checker
bind ncpd_decoder ncpd_checker u_chk (.clk, .rst_n, .instr, .instrValid, .instrReady,
	.holdReleaseEnables, .interruptGlobalEnable, .port1EnableFlags, .divider1LowClear,
	.watchdogRestart, .holdMode, .stopMode);
`default_nettype wire

// >>> verif/ncpd_prog_mem.sv
// Program memory model offering instruction words
`timescale 1ns/1ns
`default_nettype none
module ncpd_prog_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instrReady,
	output logic [15:0] instr,
	output logic instrValid
);
	logic [15:0] q[$];
	int gap = 0;
	int waitN = 0;
	// Idle word toggles so a stale fetch never looks valid
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instrValid <= 1'h0;
			instr <= 16'h5a5a;
		end else if (instrValid && instrReady) begin
			instrValid <= 1'h0;
			instr <= ~instr;
			waitN <= gap;
		end else if (!instrValid) begin
			instr <= ~instr;
			if (waitN > 0) waitN <= waitN - 1;
			else if (q.size() > 0) begin
				instrValid <= 1'h1;
				instr <= q.pop_front();
			end
		end
	end
endmodule : ncpd_prog_mem
`default_nettype wire

// >>> verif/ncpd_decoder_tb_top.sv
// Self-checking bench for the peripheral opcode decoder
`timescale 1ns/1ns
`default_nettype none
module ncpd_decoder_tb_top;
	import ncpd_pkg::*;
	logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic portdEvent = 1'h0, serialPinIn = 1'h0, err, cf = 1'h0, zf;
	logic [11:0] paddr = 12'h0, portStatusSet = 12'h0, ps, portStatus;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] eventFlags = 8'h0, wakePins = 8'h0, timer0Count = 8'h0, timer1Count = 8'h0;
	logic [7:0] v, b, holdReleaseEnables, interruptEnableFlags, stopWakeupEnables;
	logic [7:0] timer0Preset, timer1Preset;
	logic [15:0] instr;
	logic [3:0] acc, a2, a5, a6, n, portEnableFlags, port1EnableFlags, serialControlSetting;
	logic [3:0] toneEnableControl, toneSelect, systemClockSetting;
	logic [2:0] displayContrastSetting;
	logic instrValid, instrReady, pready, pslverr, serialPinOut, serialPinOe, holdMode, stopMode;
	logic portdHoldReleaseEnable, interruptGlobalEnable, displayOn, divider0LowClear;
	int failures = 0, checked = 0, seed = 32'hfbdddfba, k;
	ncpd_decoder dut (.clk, .rst_n, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .instr, .instrValid, .instrReady, .eventFlags, .portdEvent,
		.wakePins, .portStatusSet, .timer0Count, .timer1Count, .serialPinIn, .serialPinOut,
		.serialPinOe, .holdReleaseEnables, .portdHoldReleaseEnable, .interruptEnableFlags,
		.interruptGlobalEnable, .portEnableFlags, .port1EnableFlags, .stopWakeupEnables,
		.systemClockSetting, .portStatus, .divider0LowClear, .divider1LowClear(),
		.watchdogRestart(), .displayOn, .displayContrastSetting, .serialControlSetting,
		.toneEnableControl, .toneSelect, .timer0Preset, .timer1Preset, .holdMode, .stopMode);
	ncpd_prog_mem pm (.clk, .rst_n, .instrReady, .instr, .instrValid);
	always #5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge so a following call never drives psel twice at once
		@(posedge clk);
	endtask : apb
	// Settled check at the falling edge, then back onto a rising edge
	task automatic wt();
		do @(negedge clk); while (!(pm.q.size() == 0 && !instrValid && instrReady));
		@(posedge clk);
	endtask : wt
	task automatic go(input logic [15:0] w);
		pm.q.push_back(w);
		wt();
	endtask : go
	task automatic st();
		zf = acc == 4'h0;
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk(rd[5:0], {zf, cf, acc});
	endtask : st
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		apb(1'h0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		apb(1'h0, 12'h0f0, 32'h0);
		chk(err, 1'h1);
		apb(1'h1, ADDR_CTRL, 32'h0);
		pm.q.push_back(16'h50c0);
		repeat (9) @(posedge clk);
		chk(interruptGlobalEnable, 1'h0);
		apb(1'h1, ADDR_CTRL, 32'h1);
		wt();
		chk(interruptGlobalEnable, 1'h1);
		go(16'h5080);
		chk(interruptGlobalEnable, 1'h0);
		pm.gap = 3;
		for (k = 0; k < 4; k++) begin
			v = $random(seed);
			go({8'h41, v});
			chk(holdReleaseEnables, v);
			go({8'h51, v});
			chk(interruptEnableFlags, v);
			go({8'h52, v});
			chk(stopWakeupEnables, v);
			go({12'h430, v[3:0]});
			chk(portEnableFlags, v[3:0]);
			go({12'h330, v[3:2], 2'h0});
			chk(port1EnableFlags, {v[3:2], 2'h0});
			go({15'h1880, v[0]});
			chk(portdHoldReleaseEnable, v[0]);
			go({13'h0060, v[2:0]});
			chk(displayContrastSetting, v[2:0]);
			go({12'h348, v[7:4]});
			chk(toneEnableControl, v[7:4]);
		end
		go({12'h540, v[3:0]});
		chk(systemClockSetting, v[3:0]);
		go(16'h0200);
		chk(displayOn, 1'h1);
		go(16'h0280);
		chk(displayOn, 1'h0);
		pm.gap = 0;
		$display("loads end");
		timer0Count <= $random(seed);
		timer1Count <= $random(seed);
		@(posedge clk);
		a5 = timer0Count[3:0];
		a6 = timer1Count[7:4];
		go(16'h8f05);
		go(16'h9986);
		go(16'haa05);
		go(16'hab86);
		chk(timer0Preset[3:0], a5);
		chk(timer1Preset[7:4], a6);
		go(16'h9805);
		go(16'h9885);
		go(16'h9a06);
		go(16'h9b07);
		go(16'haa07);
		chk(timer0Preset[3:0], a6);
		go(16'h9e85);
		chk(toneSelect, a5);
		eventFlags <= v;
		for (k = 0; k < 2; k++) begin
			go({8'h5d, k[0], 7'h01});
			acc = k ? v[7:4] : v[3:0];
			st();
			go(16'haa81);
			chk(timer0Preset[7:4], acc);
		end
		ps = $random(seed);
		portStatusSet <= ps;
		@(posedge clk);
		portStatusSet <= 12'h0;
		for (k = 0; k < 3; k++) begin
			go({k == 2 ? 8'h5f : 8'h4f, k == 1, 7'h02});
			acc = ps[4 * k +: 4];
			st();
			go({8'h42, k != 0, k == 2, 6'h0});
			ps[4 * k +: 4] = 4'h0;
			chk(portStatus, ps);
		end
		$display("status end");
		go(16'h8f02);
		a2 = a5;
		for (k = 0; k < 4; k++) begin
			cf = v[k];
			go(cf ? 16'h5040 : 16'h5000);
			st();
			n = k < 2 ? {k[0] & cf, a2[3:1]} : {a2[2:0], k[0] & cf};
			cf = k < 2 ? a2[0] : a2[3];
			go({k < 2 ? 8'h4d : 8'h4c, k[0], 7'h02});
			a2 = n;
			acc = n;
			st();
		end
		go(16'h1700);
		chk(divider0LowClear, 1'h1);
		go(16'h5580);
		go(16'h1780);
		go({12'h320, v[3:0]});
		chk(serialControlSetting, v[3:0]);
		go(16'h3200);
		pm.q.push_back(16'haf05);
		do @(posedge clk); while (serialPinOe !== 1'h1);
		repeat (3) @(posedge clk);
		for (k = 7; k >= 0; k--) begin
			b[k] = serialPinOut;
			repeat (8) @(posedge clk);
		end
		wt();
		chk(b, {a5, acc});
		for (k = 0; k < 2; k++) begin
			serialPinIn <= k[0];
			go(16'h9f03);
			acc = {4{k[0]}};
			st();
			go(16'h9e83);
			chk(toneSelect, acc);
		end
		$display("serial end");
		go(16'h4101);
		go(16'h5204);
		for (k = 0; k < 2; k++) begin
			eventFlags <= 8'h02;
			wakePins <= 8'h08;
			pm.q.push_back(k ? 16'h00c0 : 16'h0080);
			repeat (12) @(posedge clk);
			chk(k ? stopMode : holdMode, 1'h1);
			if (k) wakePins <= 8'h0c;
			else eventFlags <= 8'h03;
			wt();
			chk(holdMode | stopMode, 1'h0);
		end
		$display("sleep end");
		end_of_test();
	end
endmodule : ncpd_decoder_tb_top
`default_nettype wire
